// ==== design/itc_counter.v ====
`timescale 1ns/1ps
`include "itc_map.vh"
module itc_counter (
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire       tick_i,
  input  wire       gate_i,
  input  wire       cfg_we_i,
  input  wire [5:0] cfg_i,
  input  wire       latch_cnt_i,
  input  wire       latch_sts_i,
  input  wire       wr_i,
  input  wire       rd_i,
  input  wire [7:0] wdata_i,
  output reg  [7:0] rdata_o,
  output reg        out_o
);
  reg  [5:0]  cfg_q;
  reg  [15:0] cnt_q;
  reg  [15:0] reload_q;
  reg  [15:0] olatch_q;
  reg  [7:0]  sts_q;
  reg  [7:0]  lsb_hold_q;
  reg         olatched_q;
  reg         sts_latched_q;
  reg         wr_msb_q;
  reg         rd_msb_q;
  reg         null_q;
  reg         load_pend_q;
  reg         armed_q;
  reg         gate_q;
  reg         half_q;
  wire [1:0]  rw    = cfg_q[`ITC_RW_HI:`ITC_RW_LO];
  wire [2:0]  mode  = cfg_q[`ITC_MODE_HI:`ITC_MODE_LO];
  wire        bcd   = cfg_q[`ITC_BCD_BIT];
  wire        m2    = (mode[1:0] == 2'h2); // R10
  wire        m3    = (mode[1:0] == 2'h3); // R10
  wire        trig  = gate_i & ~gate_q;
  wire        gate_ok = (m2 | m3 | mode == 3'h0 | mode == 3'h4) ? gate_i : 1'b1;
  wire [15:0] rsrc  = olatched_q ? olatch_q : cnt_q;
  // A write that completes a count must survive a load taken in the same cycle
  wire        ld_wr = wr_i && !(rw == `ITC_RW_BOTH && !wr_msb_q);

  function [15:0] dec1;
    input [15:0] v;
    input        b;
    input        by2;
    reg   [15:0] r;
    integer      k;
    begin
      r = v;
      if (!b) begin
        dec1 = by2 ? v - 16'h0002 : v - 16'h0001;
      end else begin
        for (k = 0; k < (by2 ? 2 : 1); k = k + 1) begin
          if (r[3:0] != 4'h0) r[3:0] = r[3:0] - 4'h1;
          else if (r[7:4] != 4'h0) r[7:0] = {r[7:4] - 4'h1, 4'h9};
          else if (r[11:8] != 4'h0) r[11:0] = {r[11:8] - 4'h1, 8'h99};
          else if (r[15:12] != 4'h0) r = {r[15:12] - 4'h1, 12'h999};
          else r = 16'h9999; // R11
        end
        dec1 = r;
      end
    end
  endfunction

  wire [15:0] nxt1 = dec1(cnt_q, bcd, 1'b0);
  wire [15:0] nxt2 = dec1(cnt_q, bcd, 1'b1);
  wire        at1  = (cnt_q == 16'h0001);
  wire        at2  = (cnt_q == 16'h0002);

  always @(posedge clk_i) begin
    if (srst_i) begin
      cfg_q         <= `ITC_CTRL_RST;
      cnt_q         <= 16'h0000;
      reload_q      <= 16'h0000;
      olatch_q      <= 16'h0000;
      sts_q         <= 8'h00;
      lsb_hold_q    <= 8'h00;
      olatched_q    <= 1'b0;
      sts_latched_q <= 1'b0;
      wr_msb_q      <= 1'b0;
      rd_msb_q      <= 1'b0;
      null_q        <= 1'b0;
      load_pend_q   <= 1'b0;
      armed_q       <= 1'b0;
      gate_q        <= gate_i;
      half_q        <= 1'b0;
      rdata_o       <= 8'h00;
      out_o         <= 1'b0; // R14
    end else begin
      gate_q <= gate_i;
      if (cfg_we_i) begin
        cfg_q       <= cfg_i; // R2
        wr_msb_q    <= 1'b0;
        rd_msb_q    <= 1'b0;
        olatched_q  <= 1'b0;
        null_q      <= 1'b1;
        load_pend_q <= 1'b0;
        armed_q     <= 1'b0;
        out_o       <= (cfg_i[`ITC_MODE_HI:`ITC_MODE_LO] != 3'h0); // R19
      end
      if (latch_cnt_i && !olatched_q) begin // R17
        olatch_q   <= cnt_q;
        olatched_q <= 1'b1;
      end
      if (latch_sts_i && !sts_latched_q) begin // R17
        sts_q         <= {out_o, null_q, cfg_q};
        sts_latched_q <= 1'b1;
      end
      if (wr_i) begin // R3 R9
        if (rw == `ITC_RW_BOTH && !wr_msb_q) begin // R8
          lsb_hold_q <= wdata_i;
          wr_msb_q   <= 1'b1;
          if (mode == 3'h0) out_o <= 1'b0;
        end else begin
          wr_msb_q    <= 1'b0;
          null_q      <= 1'b1;
          load_pend_q <= 1'b1;
          case (rw)
            `ITC_RW_LSB: reload_q <= {8'h00, wdata_i};
            `ITC_RW_MSB: reload_q <= {wdata_i, 8'h00};
            default:     reload_q <= {wdata_i, lsb_hold_q};
          endcase
          if (mode == 3'h0) out_o <= 1'b0;
        end
      end
      if (rd_i) begin // R9
        if (sts_latched_q) begin // R18
          rdata_o       <= sts_q;
          sts_latched_q <= 1'b0;
        end else if (rw == `ITC_RW_MSB || (rw == `ITC_RW_BOTH && rd_msb_q)) begin
          rdata_o    <= rsrc[15:8];
          rd_msb_q   <= 1'b0;
          olatched_q <= 1'b0;
        end else begin
          rdata_o    <= rsrc[7:0];
          rd_msb_q   <= (rw == `ITC_RW_BOTH);
          olatched_q <= olatched_q & (rw == `ITC_RW_BOTH);
        end
      end
      if (trig && (mode == 3'h1 || mode == 3'h5 || m2 || m3)) begin // R19
        armed_q <= 1'b1;
      end
      if (tick_i && !cfg_we_i) begin // R19
        if (load_pend_q && (!(mode == 3'h1 || mode == 3'h5) || armed_q)) begin
          cnt_q       <= reload_q;
          load_pend_q <= (mode == 3'h1 || mode == 3'h5) || ld_wr;
          null_q      <= ld_wr;
          armed_q     <= 1'b0;
          half_q      <= 1'b0;
          if (mode == 3'h1) out_o <= 1'b0;
          if (m2 | m3) out_o <= 1'b1;
          if (mode == 3'h4 || mode == 3'h5) out_o <= 1'b1;
        end else if (gate_ok) begin
          if (m3) begin
            if (at2 || cnt_q == 16'h0000 || (at1 && reload_q[0])) begin
              cnt_q  <= reload_q;
              out_o  <= ~out_o;
            end else begin
              cnt_q <= nxt2;
            end
          end else begin
            cnt_q <= nxt1;
            if (m2) begin
              if (at2) out_o <= 1'b0;
              if (at1) begin
                out_o <= 1'b1;
                cnt_q <= reload_q;
              end
            end else if (at1) begin
              if (mode == 3'h0 || mode == 3'h1) out_o <= 1'b1;
              else out_o <= 1'b0;
            end else if ((mode == 3'h4 || mode == 3'h5) && !out_o) begin
              out_o <= 1'b1;
            end
          end
        end
        if (m2 && trig) load_pend_q <= 1'b1;
      end
    end
  end
endmodule // itc_counter

// ==== design/itc_map.vh ====
// Behaviour
// R1: Three independent counters reachable by ISA or PCI I/O cycles.
// R2: Write-only 8-bit control word decoded at I/O address 043h.
// R3: After a control word, a count may be written any time later.
// R4: Control bits 7:6 select counter 0, 1 or 2.
// R5: Control bits 7:6 both one make the write a read-back command.
// R6: Control bits 5:4 both zero make the write a counter latch command.
// R7: Special commands give the remaining bits their command meanings.
// R8: Bits 5:4 pick access order: low only, high only, low then high.
// R9: Counts are loaded and read at ports 040h, 041h and 042h.
// R10: Bits 3:1 pick mode 0 to 5; bit 3 ignored for modes 2 and 3.
// R11: Bit 0 picks binary or BCD countdown.
// R12: Host writes both bytes of a two-byte count without interleaving.
// R13: Host programs every counter after reset before relying on it.
// R14: Reset drives every counter output to zero.
// R15: Reset clears speaker, timer interrupt, port 061h bit 5, refresh request.
// R16: Counters 0 and 2 usually square wave, counter 1 rate generator.
// R17: A second latch before the first is read is ignored.
// R18: With status and count latched, first read gives status, then count.
// R19: Each counter makes its mode waveform, counting on its clock with gate.
// R20: Counter 0 drives the timer interrupt, counter 2 feeds the speaker.
`ifndef ITC_MAP_VH
`define ITC_MAP_VH
`define ITC_ADDR_CNT0   8'h40
`define ITC_ADDR_CNT1   8'h41
`define ITC_ADDR_CNT2   8'h42
`define ITC_ADDR_CTRL   8'h43
`define ITC_SEL_HI      7
`define ITC_SEL_LO      6
`define ITC_RW_HI       5
`define ITC_RW_LO       4
`define ITC_MODE_HI     3
`define ITC_MODE_LO     1
`define ITC_BCD_BIT     0
`define ITC_SEL_RDBK    2'h3
`define ITC_RW_LATCH    2'h0
`define ITC_RW_LSB      2'h1
`define ITC_RW_MSB      2'h2
`define ITC_RW_BOTH     2'h3
`define ITC_RB_NCNT_BIT 5
`define ITC_RB_NSTS_BIT 4
`define ITC_RB_CNT0_BIT 1
`define ITC_CTRL_RST    6'h00
`endif

// ==== design/itc_timer.v ====
`timescale 1ns/1ps
`include "itc_map.vh"
module itc_timer #(
  parameter NUM_CNT = 3
) (
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire       io_wr_i,
  input  wire       io_rd_i,
  input  wire [7:0] io_addr_i,
  input  wire [7:0] io_wdata_i,
  output reg  [7:0] io_rdata_o,
  output wire       io_hit_o,
  input  wire [2:0] cnt_tick_i,
  input  wire [2:0] cnt_gate_i,
  input  wire       speaker_enable_i,
  output wire [2:0] cnt_out_o,
  output wire       timer_interrupt_request_o,
  output wire       speaker_output_o,
  output wire       refresh_toggle_o,
  output wire       refresh_request_o
);
  wire [7:0]  rdata [0:NUM_CNT-1];
  wire [5:0]  cfg_bits = io_wdata_i[5:0];
  wire [1:0]  sel      = io_wdata_i[`ITC_SEL_HI:`ITC_SEL_LO];
  wire        ctrl_wr  = io_wr_i && io_addr_i == `ITC_ADDR_CTRL; // R2
  wire        is_rdbk  = ctrl_wr && sel == `ITC_SEL_RDBK; // R5
  wire        is_latch = ctrl_wr && !is_rdbk
                         && io_wdata_i[`ITC_RW_HI:`ITC_RW_LO] == `ITC_RW_LATCH; // R6
  reg         refresh_q;
  reg         ctr1_out_d1_q;
  reg         refresh_req_q;

  function sel_port;
    input [7:0] a;
    input integer n;
    begin
      sel_port = (a == (`ITC_ADDR_CNT0 + n[7:0]));
    end
  endfunction

  assign io_hit_o = io_addr_i >= `ITC_ADDR_CNT0 && io_addr_i <= `ITC_ADDR_CTRL; // R1

  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g = g + 1) begin : g_cnt
      wire cfg_we = ctrl_wr && !is_rdbk && !is_latch && sel == g; // R4 R7
      wire lc     = (is_latch && sel == g) // R6 R7
                    || (is_rdbk && io_wdata_i[`ITC_RB_CNT0_BIT+g]
                        && !io_wdata_i[`ITC_RB_NCNT_BIT]); // R5 R7
      wire ls     = is_rdbk && io_wdata_i[`ITC_RB_CNT0_BIT+g] && !io_wdata_i[`ITC_RB_NSTS_BIT];
      itc_counter u_cnt (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .tick_i      (cnt_tick_i[g]),
        .gate_i      (cnt_gate_i[g]),
        .cfg_we_i    (cfg_we),
        .cfg_i       (cfg_bits),
        .latch_cnt_i (lc),
        .latch_sts_i (ls),
        .wr_i        (io_wr_i && sel_port(io_addr_i, g)), // R9
        .rd_i        (io_rd_i && sel_port(io_addr_i, g)), // R9
        .wdata_i     (io_wdata_i),
        .rdata_o     (rdata[g]),
        .out_o       (cnt_out_o[g])
      );
    end
  endgenerate

  always @* begin
    case (io_addr_i)
      `ITC_ADDR_CNT0: io_rdata_o = rdata[0];
      `ITC_ADDR_CNT1: io_rdata_o = rdata[1];
      `ITC_ADDR_CNT2: io_rdata_o = rdata[2];
      default:        io_rdata_o = 8'h00;
    endcase
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      refresh_q     <= 1'b0; // R15
      ctr1_out_d1_q <= 1'b0;
      refresh_req_q <= 1'b0; // R15
    end else begin
      ctr1_out_d1_q <= cnt_out_o[1];
      refresh_req_q <= cnt_out_o[1] & ~ctr1_out_d1_q;
      if (cnt_out_o[1] & ~ctr1_out_d1_q) refresh_q <= ~refresh_q;
    end
  end

  assign timer_interrupt_request_o = cnt_out_o[0]; // R20 R15
  assign speaker_output_o          = cnt_out_o[2] & speaker_enable_i; // R20 R15
  assign refresh_toggle_o          = refresh_q; // R15
  assign refresh_request_o         = refresh_req_q;
endmodule // itc_timer

// ==== test/itc_timer_checker.sv ====
`timescale 1ns/1ps
module itc_timer_checker (
  input wire       clk_i,
  input wire       srst_i,
  input wire [7:0] io_addr_i,
  input wire [7:0] io_rdata_o,
  input wire       io_hit_o,
  input wire       speaker_enable_i,
  input wire [2:0] cnt_out_o,
  input wire       timer_interrupt_request_o,
  input wire       speaker_output_o,
  input wire       refresh_toggle_o,
  input wire       refresh_request_o
);
  wire side_any = speaker_output_o | timer_interrupt_request_o | refresh_toggle_o | refresh_request_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  irq_map_a: assert property (timer_interrupt_request_o == cnt_out_o[0])
    else $error("timer interrupt differs from counter 0");
  spk_map_a: assert property (speaker_output_o == (cnt_out_o[2] & speaker_enable_i))
    else $error("speaker differs from counter 2 path");
  rst_out_a: assert property ($fell(srst_i) |-> cnt_out_o == 3'h0)
    else $error("counter outputs not zero after reset");
  rst_side_a: assert property ($fell(srst_i) |-> !side_any)
    else $error("side outputs not zero after reset");
  hit_dec_a: assert property (io_hit_o == (io_addr_i[7:2] == 6'h10))
    else $error("port hit decode wrong");
  ctrl_wo_a: assert property (io_addr_i == 8'h43 |-> io_rdata_o == 8'h00)
    else $error("control port returned data");
  unmap_rd_a: assert property (!io_hit_o |-> io_rdata_o == 8'h00)
    else $error("unmapped port returned data");
  rst_rd_a: assert property ($fell(srst_i) |-> io_rdata_o == 8'h00)
    else $error("read data not zero after reset");
  rfr_pulse_a: assert property (refresh_request_o |=> !refresh_request_o)
    else $error("refresh request longer than one cycle");
  cover property ($rose(cnt_out_o[0]));
  cover property (refresh_request_o);
  cover property (io_hit_o && io_addr_i == 8'h43);
endmodule // itc_timer_checker
bind itc_timer itc_timer_checker u_chk (.clk_i, .srst_i, .io_addr_i, .io_rdata_o, .io_hit_o, .speaker_enable_i,
  .cnt_out_o, .timer_interrupt_request_o, .speaker_output_o, .refresh_toggle_o, .refresh_request_o);

// ==== test/itc_tick_src.sv ====
`timescale 1ns/1ps
module itc_tick_src (
  input  wire       clk_i,
  input  wire       srst_i,
  input  wire [2:0] fire_i,
  output reg  [2:0] tick_o
);
  // Count-clock enables, each a single whole cycle
  always @(posedge clk_i) begin
    if (srst_i) begin
      tick_o <= 3'h0;
    end else begin
      tick_o <= fire_i;
    end
  end
endmodule // itc_tick_src

// ==== test/itc_timer_tb.sv ====
`timescale 1ns/1ps
module itc_timer_tb;
  reg        clk_i, srst_i, io_wr_i, io_rd_i, spk_en;
  reg  [7:0] io_addr_i, io_wdata_i;
  reg  [2:0] fire, gate;
  wire [7:0] rdata;
  wire [2:0] tick, outs;
  wire       hit, irq, spk, rtog, rreq;
  integer    error_cnt, samples_checked;
  itc_tick_src u_src (.clk_i(clk_i), .srst_i(srst_i), .fire_i(fire), .tick_o(tick));
  itc_timer dut (.clk_i(clk_i), .srst_i(srst_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(rdata), .io_hit_o(hit), .cnt_tick_i(tick), .cnt_gate_i(gate),
    .speaker_enable_i(spk_en), .cnt_out_o(outs), .timer_interrupt_request_o(irq), .speaker_output_o(spk),
    .refresh_toggle_o(rtog), .refresh_request_o(rreq));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task chk(input [7:0] seen, input [7:0] exp); begin
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
    end
  end endtask
  task wr(input [7:0] a, input [7:0] d); begin
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(posedge clk_i) #1;
    io_wr_i = 1'b0;
    @(posedge clk_i) #1;
  end endtask
  // Data is registered on the strobe edge; address held through the answer cycle
  task rd(input [7:0] a, input [7:0] exp); begin
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(posedge clk_i) #1;
    io_rd_i = 1'b0;
    chk(rdata, exp);
    @(posedge clk_i) #1;
  end endtask
  task tk(input [2:0] m, input integer n); begin
    repeat (n) begin
      fire = m;
      @(posedge clk_i) #1;
      fire = 3'h0;
      repeat (3) @(posedge clk_i);
      #1;
    end
  end endtask
  task stop_test; begin
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  end endtask
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    stop_test;
  end
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    srst_i = 1'b1;
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    io_addr_i = 8'h00;
    io_wdata_i = 8'h00;
    fire = 3'h0;
    gate = 3'h7;
    spk_en = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 srst_i = 1'b0;
    chk({5'h0, outs}, 8'h00);
    chk({4'h0, spk, irq, rtog, rreq}, 8'h00);
    $display("test reset done");
    wr(8'h43, 8'h30);
    wr(8'h40, 8'h05);
    wr(8'h40, 8'h00);
    tk(3'h1, 3);
    wr(8'h43, 8'h00);
    tk(3'h1, 1);
    wr(8'h43, 8'h00);
    rd(8'h40, 8'h03);
    rd(8'h40, 8'h00);
    tk(3'h1, 1);
    chk({7'h0, irq}, 8'h00);
    tk(3'h1, 1);
    chk({7'h0, irq}, 8'h01);
    $display("test counter 0 latch done");
    wr(8'h43, 8'hc2);
    rd(8'h40, 8'hb0);
    rd(8'h40, 8'h00);
    rd(8'h40, 8'h00);
    wr(8'h40, 8'h02);
    wr(8'h40, 8'h00);
    tk(3'h1, 1);
    wr(8'h43, 8'h00);
    rd(8'h40, 8'h02);
    rd(8'h40, 8'h00);
    $display("test read back done");
    wr(8'h43, 8'h54);
    wr(8'h41, 8'h04);
    tk(3'h2, 1);
    chk({7'h0, rtog}, 8'h01);
    wr(8'h43, 8'he4);
    rd(8'h41, 8'h94);
    tk(3'h2, 5);
    chk({7'h0, rtog}, 8'h00);
    $display("test counter 1 done");
    wr(8'h43, 8'hb1);
    wr(8'h42, 8'h10);
    wr(8'h42, 8'h00);
    tk(3'h4, 2);
    wr(8'h43, 8'h80);
    rd(8'h42, 8'h09);
    rd(8'h42, 8'h00);
    $display("test counter 2 done");
    wr(8'h43, 8'hb6);
    wr(8'h42, 8'h04);
    wr(8'h42, 8'h00);
    tk(3'h4, 2);
    chk({7'h0, spk}, 8'h01);
    tk(3'h4, 1);
    chk({7'h0, spk}, 8'h00);
    tk(3'h4, 2);
    chk({7'h0, spk}, 8'h01);
    $display("test square wave done");
    rd(8'h43, 8'h00);
    rd(8'h50, 8'h00);
    chk({7'h0, hit}, 8'h00);
    $display("test map done");
    stop_test;
  end
endmodule // itc_timer_tb
